// ### ocfr_pkg.sv
package ocfr_pkg;

    // ------------------------------------------------------------
    // response setting layout
    // ------------------------------------------------------------
    localparam int ACT_MSB = 7;
    localparam int ACT_LSB = 6;
    localparam int RTY_MSB = 5;
    localparam int RTY_LSB = 3;
    localparam int DGL_MSB = 2;
    localparam int DGL_LSB = 0;

    // reset value of both response settings
    localparam logic [7:0] RSP_RESET = 8'h00;

    // action codes
    localparam logic [1:0] ACT_CONTINUE = 2'h0;
    localparam logic [1:0] ACT_DELAYED  = 2'h1;

    // register select on the write port
    localparam logic SEL_OC = 1'b0;
    localparam logic SEL_UC = 1'b1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;           // cycles per microsecond
    localparam int DGL1_US = 100;
    localparam int DGL2_US = 1000;
    localparam int DGL3_US = 5000;
    localparam int DGL4_US = 10000;
    localparam int DGL5_US = 20000;
    localparam int DGL6_US = 50000;
    localparam int DGL7_US = 100000;
    localparam int DGL_W   = 24;            // holds 100 ms of cycles

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] action;
        logic [2:0] restart;
        logic [2:0] deglitch;
    } ocfr_rsp_type;

    typedef struct packed {
        logic status_byte_bit;              // overcurrent in status byte
        logic status_word_bit;              // any current fault
        logic oc_bit;                       // output current register
        logic uc_bit;                       // output current register
    } ocfr_status_type;

endpackage : ocfr_pkg

// ### ocfr_deglitch.sv
`timescale 1ns/10ps
module ocfr_deglitch
    import ocfr_pkg::*;
(
    input  wire logic             clk,      // core clock
    input  wire logic             rst,      // async reset, high
    input  wire logic             raw,      // fault from supervisor
    input  wire logic             bypass,   // no deglitch applied
    input  wire logic [DGL_W-1:0] limit,    // cycles to ignore fault
    output logic                  qual      // fault survived deglitch
);

    logic [DGL_W-1:0] cnt_q;
    logic [DGL_W-1:0] cnt_d;

    // count cycles of continuous fault; any gap restarts the wait
    always_comb begin
        cnt_d = cnt_q;
        if (!raw) begin
            cnt_d = '0;
        end else if (cnt_q < limit) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // code zero passes the fault straight through
    assign qual = raw && (bypass || cnt_q >= limit);

endmodule : ocfr_deglitch

// ### ocfr_top.sv
`timescale 1ns/10ps
module ocfr_top
    import ocfr_pkg::*;
#(
    parameter int DGL1_CYC = DGL1_US * CLK_MHZ,
    parameter int DGL2_CYC = DGL2_US * CLK_MHZ,
    parameter int DGL3_CYC = DGL3_US * CLK_MHZ,
    parameter int DGL4_CYC = DGL4_US * CLK_MHZ,
    parameter int DGL5_CYC = DGL5_US * CLK_MHZ,
    parameter int DGL6_CYC = DGL6_US * CLK_MHZ,
    parameter int DGL7_CYC = DGL7_US * CLK_MHZ
)(
    input  wire logic       clk,            // core clock, 125 MHz
    input  wire logic       rst,            // async reset, high
    input  wire logic       oc_raw,         // overcurrent detected
    input  wire logic       uc_raw,         // undercurrent detected
    input  wire logic       reg_wr,         // write strobe
    input  wire logic       reg_sel,        // 0 overcurrent, 1 under
    input  wire logic [7:0] reg_wdata,      // setting to write
    output logic      [7:0] oc_rsp_rdata,   // overcurrent setting
    output logic      [7:0] uc_rsp_rdata,   // undercurrent setting
    input  wire logic       control_on,     // pin and command say on
    input  wire logic       bias_ok,        // bias power present
    input  wire logic       other_fault,    // other fault shut down
    input  wire logic       seq_off_en,     // sequenced turn-off
    input  wire logic       toff_done,      // turn-off delay over
    input  wire logic       retry_tick,     // retry interval over
    input  wire logic [2:0] retry_limit,    // global retry count
    input  wire logic       clear_faults,   // clear status pulse
    output logic            chan_en,        // channel enabled
    output logic            seq_off_req,    // turn-off sequence busy
    output logic            fault_off,      // held off by this or another fault
    output ocfr_status_type status,         // status bits
    output logic            alert_n_output  // alert to host, low
);

    // ------------------------------------------------------------
    // response settings
    // ------------------------------------------------------------
    ocfr_rsp_type oc_rsp_q;
    ocfr_rsp_type oc_rsp_d;
    ocfr_rsp_type uc_rsp_q;
    ocfr_rsp_type uc_rsp_d;

    always_comb begin
        oc_rsp_d = oc_rsp_q;
        uc_rsp_d = uc_rsp_q;
        if (reg_wr && reg_sel == SEL_OC) begin
            oc_rsp_d = ocfr_rsp_type'(reg_wdata);
        end
        if (reg_wr && reg_sel == SEL_UC) begin
            uc_rsp_d = ocfr_rsp_type'(reg_wdata);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oc_rsp_q <= ocfr_rsp_type'(RSP_RESET);
            uc_rsp_q <= ocfr_rsp_type'(RSP_RESET);
        end else begin
            oc_rsp_q <= oc_rsp_d;
            uc_rsp_q <= uc_rsp_d;
        end
    end

    assign oc_rsp_rdata = oc_rsp_q;
    assign uc_rsp_rdata = uc_rsp_q;

    // ------------------------------------------------------------
    // deglitch
    // ------------------------------------------------------------
    // code to interval, in cycles
    function automatic logic [DGL_W-1:0] dgl_limit(input logic [2:0] code);
        case (code)
            3'h1:    dgl_limit = DGL_W'(DGL1_CYC);
            3'h2:    dgl_limit = DGL_W'(DGL2_CYC);
            3'h3:    dgl_limit = DGL_W'(DGL3_CYC);
            3'h4:    dgl_limit = DGL_W'(DGL4_CYC);
            3'h5:    dgl_limit = DGL_W'(DGL5_CYC);
            3'h6:    dgl_limit = DGL_W'(DGL6_CYC);
            3'h7:    dgl_limit = DGL_W'(DGL7_CYC);
            default: dgl_limit = '0;
        endcase
    endfunction : dgl_limit

    // action decode: fault that counts for this setting
    function automatic logic seen(input ocfr_rsp_type rsp,
                                  input logic raw, input logic qual);
        // immediate actions skip the deglitch wait
        if (rsp.action[1]) begin
            seen = raw;
        end else begin
            seen = qual;
        end
    endfunction : seen

    logic oc_qual;
    logic uc_qual;

    ocfr_deglitch u_oc_dgl (
        .clk    (clk),
        .rst    (rst),
        .raw    (oc_raw),
        .bypass (oc_rsp_q.deglitch == 3'h0),
        .limit  (dgl_limit(oc_rsp_q.deglitch)),
        .qual   (oc_qual)
    );

    ocfr_deglitch u_uc_dgl (
        .clk    (clk),
        .rst    (rst),
        .raw    (uc_raw),
        .bypass (uc_rsp_q.deglitch == 3'h0),
        .limit  (dgl_limit(uc_rsp_q.deglitch)),
        .qual   (uc_qual)
    );

    logic oc_seen;
    logic uc_seen;
    logic trip;

    assign oc_seen = seen(oc_rsp_q, oc_raw, oc_qual);
    assign uc_seen = seen(uc_rsp_q, uc_raw, uc_qual);
    // continue action never trips the channel, nor clamps it
    assign trip = (oc_seen && oc_rsp_q.action != ACT_CONTINUE) ||
                  (uc_seen && uc_rsp_q.action != ACT_CONTINUE);

    // ------------------------------------------------------------
    // status and alert
    // ------------------------------------------------------------
    logic oc_flag_q;
    logic oc_flag_d;
    logic uc_flag_q;
    logic uc_flag_d;
    logic alert_n_q;
    logic alert_n_d;

    // a fault in the clearing cycle still sets its flag
    always_comb begin
        oc_flag_d = (oc_flag_q && !clear_faults) || oc_seen;
        uc_flag_d = (uc_flag_q && !clear_faults) || uc_seen;
        alert_n_d = !(oc_flag_d || uc_flag_d);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            oc_flag_q <= 1'b0;
            uc_flag_q <= 1'b0;
            alert_n_q <= 1'b1;
        end else begin
            oc_flag_q <= oc_flag_d;
            uc_flag_q <= uc_flag_d;
            alert_n_q <= alert_n_d;
        end
    end

    assign status.status_byte_bit = oc_flag_q;
    assign status.status_word_bit = oc_flag_q || uc_flag_q;
    assign status.oc_bit          = oc_flag_q;
    assign status.uc_bit          = uc_flag_q;
    assign alert_n_output         = alert_n_q;

    // ------------------------------------------------------------
    // channel sequencing
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_OFF,
        ST_ON,
        ST_SEQ_OFF,
        ST_RETRY_WAIT,
        ST_LATCHED
    } ocfr_state_type;

    ocfr_state_type state_q;
    ocfr_state_type state_d;
    logic [2:0]     oc_pol_q;               // policy taken at turn-on
    logic [2:0]     oc_pol_d;
    logic [2:0]     uc_pol_q;
    logic [2:0]     uc_pol_d;
    logic [2:0]     tries_q;
    logic [2:0]     tries_d;
    logic           cause_oc_q;             // which fault tripped
    logic           cause_oc_d;
    logic           may_retry;

    // policy of the fault that tripped, as frozen at turn-on
    assign may_retry = ((cause_oc_q ? oc_pol_q : uc_pol_q) != 3'h0) &&
                       (tries_q < retry_limit);

    always_comb begin
        state_d    = state_q;
        oc_pol_d   = oc_pol_q;
        uc_pol_d   = uc_pol_q;
        tries_d    = tries_q;
        cause_oc_d = cause_oc_q;
        // commanded off or bias loss ends any state and clears latch
        if (!control_on || !bias_ok) begin
            state_d = ST_OFF;
        end else begin
            case (state_q)
                ST_OFF: begin
                    // restart settings written since last turn-on apply here
                    oc_pol_d = oc_rsp_q.restart;
                    uc_pol_d = uc_rsp_q.restart;
                    tries_d  = 3'h0;
                    state_d  = ST_ON;
                end
                ST_ON: begin
                    if (other_fault) begin
                        state_d = ST_LATCHED;
                    end else if (trip) begin
                        cause_oc_d = oc_seen &&
                                     oc_rsp_q.action != ACT_CONTINUE;
                        state_d = seq_off_en ? ST_SEQ_OFF :
                                               ST_RETRY_WAIT;
                    end
                end
                ST_SEQ_OFF: begin
                    if (toff_done) begin
                        state_d = ST_RETRY_WAIT;
                    end
                end
                ST_RETRY_WAIT: begin
                    if (other_fault || !may_retry) begin
                        state_d = ST_LATCHED;
                    end else if (retry_tick) begin
                        tries_d = tries_q + 3'h1;
                        state_d = ST_ON;
                    end
                end
                ST_LATCHED: begin
                    state_d = ST_LATCHED;
                end
                default: begin
                    state_d = ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q    <= ST_OFF;
            oc_pol_q   <= 3'h0;
            uc_pol_q   <= 3'h0;
            tries_q    <= 3'h0;
            cause_oc_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            oc_pol_q   <= oc_pol_d;
            uc_pol_q   <= uc_pol_d;
            tries_q    <= tries_d;
            cause_oc_q <= cause_oc_d;
        end
    end

    // ------------------------------------------------------------
    // channel outputs
    // ------------------------------------------------------------
    logic chan_en_q;
    logic chan_en_d;
    logic seq_q;
    logic seq_d;
    logic foff_q;
    logic foff_d;

    // registered so the channel pins never glitch on decode
    always_comb begin
        chan_en_d = state_d == ST_ON || state_d == ST_SEQ_OFF;
        seq_d     = state_d == ST_SEQ_OFF;
        foff_d    = state_d == ST_RETRY_WAIT ||
                    state_d == ST_LATCHED;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chan_en_q <= 1'b0;
            seq_q     <= 1'b0;
            foff_q    <= 1'b0;
        end else begin
            chan_en_q <= chan_en_d;
            seq_q     <= seq_d;
            foff_q    <= foff_d;
        end
    end

    assign chan_en     = chan_en_q;
    assign seq_off_req = seq_q;
    assign fault_off   = foff_q;

endmodule : ocfr_top

// ### ocfr_chk.sv
`timescale 1ns/10ps
module ocfr_chk
    import ocfr_pkg::*;
#(
    parameter int DGL1_CYC = DGL1_US * CLK_MHZ
)(
    input wire logic            clk,            // core clock
    input wire logic            rst,            // async reset, high
    input wire logic            oc_raw,         // overcurrent seen
    input wire logic            uc_raw,         // undercurrent seen
    input wire logic [7:0]      oc_rsp_rdata,   // overcurrent setting
    input wire logic [7:0]      uc_rsp_rdata,   // undercurrent setting
    input wire logic            control_on,     // commanded on
    input wire logic            bias_ok,        // bias present
    input wire logic            other_fault,    // foreign shutdown
    input wire logic            seq_off_en,     // sequenced turn-off
    input wire logic            toff_done,      // turn-off delay over
    input wire logic            clear_faults,   // clear status pulse
    input wire logic            chan_en,        // channel enabled
    input wire logic            seq_off_req,    // turn-off busy
    input wire logic            fault_off,      // held off by fault
    input wire ocfr_status_type status,         // status bits
    input wire logic            alert_n_output  // alert, low
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [23:0] run_q;
    logic [23:0] run_d;
    logic        keep_on;

    // -----------------------------------------------------------
    // helper logic
    // -----------------------------------------------------------
    // run length of overcurrent, so long deglitch needs no repetition
    always_comb begin
        run_d = oc_raw ? run_q + 24'h1 : 24'h0;
        keep_on = control_on && bias_ok && !other_fault;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= 24'h0;
        end else begin
            run_q <= run_d;
        end
    end

    // -----------------------------------------------------------
    // properties
    // -----------------------------------------------------------
    property p_fast;
        oc_raw && (oc_rsp_rdata[7] || oc_rsp_rdata[2:0] == 3'h0)
            |=> status.oc_bit;
    endproperty
    a_fast: assert property (p_fast) else $error("fast flag missing");
    property p_alert;
        alert_n_output == !(status.oc_bit || status.uc_bit);
    endproperty
    a_alert: assert property (p_alert) else $error("alert wrong");
    property p_map;
        status.status_word_bit == (status.oc_bit || status.uc_bit)
            && status.status_byte_bit == status.oc_bit;
    endproperty
    a_map: assert property (p_map) else $error("status map wrong");
    property p_stick;
        status.oc_bit && !clear_faults |=> status.oc_bit;
    endproperty
    a_stick: assert property (p_stick) else $error("flag lost");
    property p_cont;
        chan_en && !seq_off_req && keep_on && oc_rsp_rdata[7:6] == 2'h0
            && uc_rsp_rdata[7:6] == 2'h0 |=> chan_en;
    endproperty
    a_cont: assert property (p_cont) else $error("continue shut");
    property p_imm;
        chan_en && !seq_off_req && keep_on && !seq_off_en && oc_raw
            && oc_rsp_rdata[7] |=> !chan_en && fault_off;
    endproperty
    a_imm: assert property (p_imm) else $error("no stop");
    property p_seq;
        chan_en && !seq_off_req && keep_on && seq_off_en && oc_raw
            && oc_rsp_rdata[7] |=> chan_en && seq_off_req;
    endproperty
    a_seq: assert property (p_seq) else $error("no sequence");
    property p_toff;
        seq_off_req && toff_done && keep_on |=> !chan_en && fault_off;
    endproperty
    a_toff: assert property (p_toff) else $error("turn-off late");
    property p_clear;
        (!oc_raw && !uc_raw)[*2] ##0 clear_faults |=> status == 4'h0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");
    property p_dgl;
        $rose(status.oc_bit) && oc_rsp_rdata[2:0] == 3'h1
            && !oc_rsp_rdata[7] |-> run_q > DGL1_CYC;
    endproperty
    a_dgl: assert property (p_dgl) else $error("deglitch short");
    c_seq: cover property (seq_off_req && toff_done);
    c_alert: cover property ($fell(alert_n_output));
    c_retry: cover property (fault_off ##1 chan_en);
endmodule : ocfr_chk

bind ocfr_top ocfr_chk #(.DGL1_CYC(DGL1_CYC)) u_chk (
    .clk, .rst, .oc_raw, .uc_raw, .oc_rsp_rdata, .uc_rsp_rdata,
    .control_on, .bias_ok, .other_fault, .seq_off_en, .toff_done,
    .clear_faults, .chan_en, .seq_off_req, .fault_off, .status,
    .alert_n_output);

// ### ocfr_host.sv
`timescale 1ns/10ps
module ocfr_host
    import ocfr_pkg::*;
#(
    parameter int WAIT_CYC = 3                  // host reaction time
)(
    input  wire logic            clk,           // core clock
    input  wire logic            rst,           // async reset, high
    input  wire logic            alert_n_output,// alert from device
    input  wire ocfr_status_type status,        // status read back
    input  wire logic            clr_en,        // host may clear
    output logic                 clear_faults,  // clear status pulse
    output ocfr_status_type      last_status    // status at read
);
    int wait_q;

    // -----------------------------------------------------------
    // alert service
    // -----------------------------------------------------------
    // slow host: waits before reading, so alert must hold low
    always @(negedge clk or posedge rst) begin
        if (rst) begin
            wait_q <= 0;
            clear_faults <= 1'b0;
            last_status <= '0;
        end else begin
            clear_faults <= 1'b0;
            if (!alert_n_output && clr_en && !clear_faults) begin
                wait_q <= wait_q + 1;
                if (wait_q >= WAIT_CYC) begin
                    wait_q <= 0;
                    last_status <= status;
                    clear_faults <= 1'b1;
                end
            end else begin
                wait_q <= 0;
            end
        end
    end
endmodule : ocfr_host

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import ocfr_pkg::*;
    logic clk, rst, oc_raw, uc_raw, reg_wr, reg_sel, control_on;
    logic bias_ok, other_fault, seq_off_en, toff_done, retry_tick;
    logic clr_en, clear_faults, chan_en, seq_off_req, fault_off;
    logic alert_n_output, m_oc, m_uc;
    logic [7:0] reg_wdata, oc_rsp_rdata, uc_rsp_rdata;
    logic [2:0] retry_limit;
    ocfr_status_type status;
    int error_cnt = 0;
    int check_count = 0;
    ocfr_status_type last_st;
    localparam int lim [8] = '{0, 4, 8, 12, 16, 20, 24, 28};

    // short deglitch intervals keep the run brief; model shares the table
    ocfr_top #(.DGL1_CYC(lim[1]), .DGL2_CYC(lim[2]), .DGL3_CYC(lim[3]),
        .DGL4_CYC(lim[4]), .DGL5_CYC(lim[5]), .DGL6_CYC(lim[6]),
        .DGL7_CYC(lim[7])) u_dut (
        .clk, .rst, .oc_raw, .uc_raw, .reg_wr, .reg_sel, .reg_wdata,
        .oc_rsp_rdata, .uc_rsp_rdata, .control_on, .bias_ok,
        .other_fault, .seq_off_en, .toff_done, .retry_tick,
        .retry_limit, .clear_faults, .chan_en, .seq_off_req,
        .fault_off, .status, .alert_n_output);
    ocfr_host u_host (.clk, .rst, .alert_n_output, .status, .clr_en,
        .clear_faults, .last_status(last_st));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // -----------------------------------------------------------
    // tasks
    // -----------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // status model: flags stick until cleared, alert mirrors them
    task automatic chk_st;
        chk({status, alert_n_output}, {m_oc, m_oc | m_uc, m_oc, m_uc,
            ~(m_oc | m_uc)});
    endtask : chk_st
    task automatic cyc(input int n);
        reg_wr = 1'b0;
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic wr(input logic sel, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_sel = sel;
        reg_wdata = d;
        @(negedge clk);
        chk(sel ? uc_rsp_rdata : oc_rsp_rdata, d);
    endtask : wr
    task automatic clr;
        clr_en = 1'b1;
        cyc(12);
        clr_en = 1'b0;
        chk(last_st, {m_oc, m_oc | m_uc, m_oc, m_uc});
        m_oc = 1'b0;
        m_uc = 1'b0;
        chk_st();
    endtask : clr
    task automatic cycle_on;
        control_on = 1'b0;
        cyc(2);
        control_on = 1'b1;
        cyc(2);
    endtask : cycle_on
    task automatic trip;
        oc_raw = 1'b1;
        cyc(lim[1] + 3);
        oc_raw = 1'b0;
        m_oc = 1'b1;
    endtask : trip
    task automatic toff;
        toff_done = 1'b1;
        cyc(1);
        toff_done = 1'b0;
        cyc(1);
    endtask : toff
    task automatic tick;
        retry_tick = 1'b1;
        cyc(1);
        retry_tick = 1'b0;
        cyc(2);
    endtask : tick
    task automatic conclude;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    initial begin
        #200000;
        error_cnt++;
        conclude();
    end

    // -----------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------
    initial begin
        {oc_raw, uc_raw, reg_wr, reg_sel, reg_wdata, other_fault} = '0;
        {seq_off_en, toff_done, retry_tick, retry_limit, clr_en} = '0;
        {m_oc, m_uc} = 2'h0;
        control_on = 1'b1;
        bias_ok = 1'b1;
        rst = 1'b1;
        void'($urandom(74));
        cyc(4);
        chk(oc_rsp_rdata, RSP_RESET);
        chk(uc_rsp_rdata, RSP_RESET);
        chk({chan_en, seq_off_req, fault_off}, 8'h0);
        chk_st();
        rst = 1'b0;
        cyc(2);
        chk(chan_en, 8'h1);
        for (int i = 0; i < 6; i++) begin
            wr(i[0], 8'($urandom));
        end
        wr(SEL_OC, 8'h00);
        wr(SEL_UC, 8'h00);
        cyc(1);
        // one-cycle spike must still register with no deglitch
        oc_raw = 1'b1;
        cyc(1);
        oc_raw = 1'b0;
        m_oc = 1'b1;
        cyc(1);
        chk_st();
        chk({chan_en, fault_off}, 8'h2);
        clr();
        for (int k = 1; k < 8; k++) begin
            wr(SEL_UC, 8'(k));
            uc_raw = 1'b1;
            cyc(lim[k]);
            uc_raw = 1'b0;
            cyc(2);
            chk_st();
            uc_raw = 1'b1;
            cyc(lim[k] + 1);
            uc_raw = 1'b0;
            m_uc = 1'b1;
            chk_st();
            clr();
        end
        for (int a = 2; a < 4; a++) begin
            wr(SEL_OC, {a[1:0], 6'h00});
            cycle_on();
            chk(chan_en, 8'h1);
            oc_raw = 1'b1;
            cyc(1);
            oc_raw = 1'b0;
            m_oc = 1'b1;
            chk_st();
            chk({chan_en, fault_off}, 8'h1);
            tick();
            chk({chan_en, fault_off}, 8'h1);
            clr();
        end
        retry_limit = 3'h1;
        seq_off_en = 1'b1;
        wr(SEL_OC, 8'h49);
        cycle_on();
        oc_raw = 1'b1;
        cyc(2);
        oc_raw = 1'b0;
        cyc(2);
        chk_st();
        chk({chan_en, seq_off_req, fault_off}, 8'h4);
        trip();
        chk({chan_en, seq_off_req, fault_off}, 8'h6);
        chk_st();
        toff();
        chk({chan_en, seq_off_req, fault_off}, 8'h1);
        tick();
        chk({chan_en, seq_off_req, fault_off}, 8'h4);
        trip();
        toff();
        tick();
        chk({chan_en, seq_off_req, fault_off}, 8'h1);
        retry_limit = 3'h3;
        wr(SEL_OC, 8'h89);
        cycle_on();
        wr(SEL_OC, 8'h81);
        trip();
        toff();
        tick();
        chk(chan_en, 8'h1);
        other_fault = 1'b1;
        cyc(1);
        other_fault = 1'b0;
        tick();
        chk(chan_en, 8'h0);
        bias_ok = 1'b0;
        cyc(2);
        bias_ok = 1'b1;
        cyc(2);
        chk(chan_en, 8'h1);
        trip();
        toff();
        tick();
        chk({chan_en, seq_off_req, fault_off}, 8'h1);
        clr();
        conclude();
    end
endmodule : tb_top
